// ### verilog/med_pkg.sv
// Constants and carrier types for the motion event detector.
// Assumes a byte-wide register write port and one sample per sample_valid pulse.
package med_pkg;
   // Register offsets and register reset value
   localparam logic [7:0] TILT_FLIP_DEBOUNCE_ADDR    = 8'h42;
   localparam logic [7:0] AM_THR_L_ADDR = 8'h43;
   localparam logic [7:0] AM_THR_H_ADDR = 8'h44;
   localparam logic [7:0] ANYMOTION_DEBOUNCE_ADDR    = 8'h45;
   localparam logic [7:0] SHAKE_DELTA_THRESHOLD_L_ADDR = 8'h46;
   localparam logic [7:0] SHAKE_DELTA_THRESHOLD_H_ADDR = 8'h47;
   localparam logic [7:0] PK_L_ADDR     = 8'h48;
   localparam logic [7:0] PK_H_ADDR     = 8'h49;
   localparam logic [7:0] TIMER_ADDR    = 8'h4a;
   localparam logic [7:0] INT_STAT_ADDR = 8'h14;
   localparam logic [7:0] REG_RESET     = 8'h00;
   // Interrupt status bit positions
   localparam int TILT_BIT   = 0;
   localparam int FLIP_BIT   = 1;
   localparam int MOTION_BIT = 2;
   localparam int SHAKE_BIT  = 3;
   localparam int T35_BIT    = 4;
   // Field positions
   localparam int SHK_CNT_LSB = 4;
   localparam int TP_LSB      = 4;
   localparam int LATCH_EN_BIT = 7;
   // Timing
   localparam int CLK_HZ       = 100_000_000;
   localparam int SLOW_HZ      = 10;
   localparam int SLOW_DIV     = CLK_HZ / SLOW_HZ;
   localparam int T35_BASE_TK  = 16;   // 1.6 s in 100 ms ticks
   localparam int T35_STEP_TK  = 2;    // 0.2 s per code
   localparam int TP_BASE_TK   = 2;    // 200 ms in ticks
   typedef struct packed {
      logic        valid;
      logic [15:0] x;
      logic [15:0] y;
      logic [15:0] z;
   } med_sample_t;
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] data;
   } med_wr_t;
endpackage : med_pkg

// ### verilog/med_core.sv
// Motion event detector: any-motion, shake, tilt/flip debounce, tilt-35 and temp latch timing.
// Assumes samples arrive as signed 16-bit words and register writes come as single-cycle strobes.
// How it works
// - Tilt/flip status sets only after the condition lasts longer than the debounce count.
// - Any-motion is flagged when a per-axis sample delta exceeds the 15-bit threshold.
// - The any-motion flag lives at status bit 2.
// - Any-motion status clears after the debounce count passes with no new motion.
// - Shake is detected when a per-axis delta exceeds the 16-bit shake threshold.
// - A 12-bit peak width threshold and a 3-bit shake count threshold sit in 0x48/0x49.
// - On shake the counter increments and the peak width is measured.
// - After shake ends the peak-to-peak interval is measured and counting continues.
// - Each surpassed peak or peak-to-peak threshold bumps the count; above threshold sets bit 3.
// - Tilt-35 validity and temp latch period are timed by a 10 Hz tick.
// - Tilt-35 code n maps to 1.6 s plus 0.2 s per step.
// - Temp latch code n maps to 200 ms doubled per step; codes 6 and 7 are reserved.
// - Temp latch timeout applies only when the latch enable bit is set.
// - A valid tilt-35 detection sets status bit 4.
// - Sample above the orientation threshold is tilt, below is flat/flip.
`timescale 1ns/1ns
`default_nettype none
module med_core
(
   // Clock and reset
   input  wire logic          ref_clk_in,
   input  wire logic          rst_in,
   // Register writes and sample stream
   input  wire med_pkg::med_wr_t     reg_wr_in,
   input  wire med_pkg::med_sample_t sample_in,
   // Orientation threshold and tilt-35 source from neighbouring logic
   input  wire logic [14:0]   orientation_threshold_in,
   input  wire logic          tilt35_cond_in,
   // Results
   output logic [7:0]         int_status_out,
   output logic               temp_latch_out
);
   import med_pkg::*;
   typedef enum logic [2:0] {
      MED_SH_IDLE = 3'b001,
      MED_SH_PEAK = 3'b010,
      MED_SH_GAP  = 3'b100
   } med_sh_state_t;

   // Configuration
   logic [7:0]  tilt_flip_debounce_time_reg, tilt_flip_debounce_next;
   logic [14:0] motion_delta_threshold_reg, am_thr_next;
   logic [7:0]  motion_hold_time_reg, anymotion_debounce_next;
   logic [15:0] shake_delta_threshold_reg, shake_delta_threshold_next;
   logic [11:0] peak_width_threshold_reg, pk_next;
   logic [2:0]  shake_count_threshold_reg, sc_next;
   logic [7:0]  timer_ctrl_reg, timer_next;

   always_comb begin
      tilt_flip_debounce_next  = tilt_flip_debounce_time_reg;
      am_thr_next = motion_delta_threshold_reg;
      anymotion_debounce_next  = motion_hold_time_reg;
      shake_delta_threshold_next = shake_delta_threshold_reg;
      pk_next     = peak_width_threshold_reg;
      sc_next     = shake_count_threshold_reg;
      timer_next  = timer_ctrl_reg;
      if (reg_wr_in.wr) begin
         case (reg_wr_in.addr)
            TILT_FLIP_DEBOUNCE_ADDR:    tilt_flip_debounce_next = reg_wr_in.data;
            AM_THR_L_ADDR: am_thr_next[7:0] = reg_wr_in.data;
            AM_THR_H_ADDR: am_thr_next[14:8] = reg_wr_in.data[6:0];
            ANYMOTION_DEBOUNCE_ADDR:    anymotion_debounce_next = reg_wr_in.data;
            SHAKE_DELTA_THRESHOLD_L_ADDR: shake_delta_threshold_next[7:0] = reg_wr_in.data;
            SHAKE_DELTA_THRESHOLD_H_ADDR: shake_delta_threshold_next[15:8] = reg_wr_in.data;
            PK_L_ADDR:     pk_next[7:0] = reg_wr_in.data;
            PK_H_ADDR: begin
               pk_next[11:8] = reg_wr_in.data[3:0];
               sc_next       = reg_wr_in.data[SHK_CNT_LSB +: 3];
            end
            TIMER_ADDR:    timer_next = reg_wr_in.data;
            default: ;
         endcase
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         tilt_flip_debounce_time_reg <= REG_RESET;
         motion_delta_threshold_reg  <= 15'h0000;
         motion_hold_time_reg        <= REG_RESET;
         shake_delta_threshold_reg   <= 16'h0000;
         peak_width_threshold_reg    <= 12'h000;
         shake_count_threshold_reg   <= 3'h0;
         timer_ctrl_reg              <= REG_RESET;
      end else begin
         tilt_flip_debounce_time_reg <= tilt_flip_debounce_next;
         motion_delta_threshold_reg  <= am_thr_next;
         motion_hold_time_reg        <= anymotion_debounce_next;
         shake_delta_threshold_reg   <= shake_delta_threshold_next;
         peak_width_threshold_reg    <= pk_next;
         shake_count_threshold_reg   <= sc_next;
         timer_ctrl_reg              <= timer_next;
      end
   end

   // Sample deltas as magnitudes; 17 bits so the largest swing cannot wrap
   logic [15:0] prev_x_reg, prev_y_reg, prev_z_reg;
   logic        have_prev_reg;
   logic [16:0] dx, dy, dz;

   function automatic logic [16:0] mag(input logic [15:0] a, input logic [15:0] b);
      logic signed [16:0] d;
      d = 17'($signed(a)) - 17'($signed(b));
      mag = d[16] ? 17'(-d) : 17'(d);
   endfunction : mag
   always_comb begin
      dx = mag(sample_in.x, prev_x_reg);
      dy = mag(sample_in.y, prev_y_reg);
      dz = mag(sample_in.z, prev_z_reg);
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         prev_x_reg    <= 16'h0000;
         prev_y_reg    <= 16'h0000;
         prev_z_reg    <= 16'h0000;
         have_prev_reg <= 1'b0;
      end else if (sample_in.valid) begin
         prev_x_reg    <= sample_in.x;
         prev_y_reg    <= sample_in.y;
         prev_z_reg    <= sample_in.z;
         have_prev_reg <= 1'b1;
      end
   end

   logic motion_hit, shake_hit, shake_now;
   assign motion_hit = sample_in.valid && have_prev_reg &&
                       (dx > {2'b00, motion_delta_threshold_reg} ||
                        dy > {2'b00, motion_delta_threshold_reg} ||
                        dz > {2'b00, motion_delta_threshold_reg});
   assign shake_now  = dx > {1'b0, shake_delta_threshold_reg} ||
                       dy > {1'b0, shake_delta_threshold_reg} ||
                       dz > {1'b0, shake_delta_threshold_reg};
   assign shake_hit  = sample_in.valid && have_prev_reg && shake_now;

   // 10 Hz tick from the reference clock
   logic [$clog2(SLOW_DIV)-1:0] div_reg, div_next;
   logic tick_reg, tick_next;
   always_comb begin
      tick_next = 1'b0;
      div_next  = div_reg + 1'b1;
      if (div_reg == ($clog2(SLOW_DIV))'(SLOW_DIV - 1)) begin
         div_next  = '0;
         tick_next = 1'b1;
      end
   end
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         div_reg  <= '0;
         tick_reg <= 1'b0;
      end else begin
         div_reg  <= div_next;
         tick_reg <= tick_next;
      end
   end

   // Tilt/flip debounce, any-motion hold, shake counter, tilt-35, temp latch
   med_sh_state_t sh_state_reg, sh_state_next;
   logic [11:0] width_reg, width_next;
   logic [3:0]  shake_cnt_reg, shake_cnt_next;
   logic [8:0]  tf_cnt_reg, tf_cnt_next;
   logic        tf_tilt_reg, tf_tilt_next;
   logic [8:0]  am_cnt_reg, am_cnt_next;
   logic [5:0]  t35_cnt_reg, t35_cnt_next;
   logic [6:0]  tp_cnt_reg, tp_cnt_next;
   logic        latch_reg, latch_next;
   logic [7:0]  stat_reg, stat_next;
   logic        tilt_now, host_clr;
   logic [5:0]  t35_len;
   logic [6:0]  tp_len;
   logic [2:0]  tp_code;

   assign tilt_now = sample_in.z[14:0] > orientation_threshold_in;
   assign host_clr = reg_wr_in.wr && reg_wr_in.addr == INT_STAT_ADDR;
   assign t35_len  = 6'(T35_BASE_TK + T35_STEP_TK * timer_ctrl_reg[2:0]);
   assign tp_code  = timer_ctrl_reg[TP_LSB +: 3];
   // Reserved codes fall back to the longest legal period
   assign tp_len   = (tp_code > 3'd5) ? 7'(TP_BASE_TK << 5) : 7'(TP_BASE_TK << tp_code);

   always_comb begin
      stat_next      = stat_reg;
      sh_state_next  = sh_state_reg;
      width_next     = width_reg;
      shake_cnt_next = shake_cnt_reg;
      tf_cnt_next    = tf_cnt_reg;
      tf_tilt_next   = tf_tilt_reg;
      am_cnt_next    = am_cnt_reg;
      t35_cnt_next   = t35_cnt_reg;
      tp_cnt_next    = tp_cnt_reg;
      latch_next     = latch_reg;
      if (host_clr)
         stat_next = stat_reg & ~reg_wr_in.data;
      // Tilt/flip debounce counted in samples
      if (sample_in.valid) begin
         if (tilt_now != tf_tilt_reg) begin
            tf_tilt_next = tilt_now;
            tf_cnt_next  = 9'h000;
         end else if (tf_cnt_reg <= {1'b0, tilt_flip_debounce_time_reg}) begin
            tf_cnt_next = tf_cnt_reg + 9'h001;
         end else begin
            stat_next[TILT_BIT] = tilt_now;
            stat_next[FLIP_BIT] = !tilt_now;
         end
      end
      // Any-motion: set on hit, clear after a quiet debounce span
      if (motion_hit) begin
         stat_next[MOTION_BIT] = 1'b1;
         am_cnt_next = 9'h000;
      end else if (sample_in.valid && stat_reg[MOTION_BIT]) begin
         if (am_cnt_reg >= {1'b0, motion_hold_time_reg})
            stat_next[MOTION_BIT] = 1'b0;
         else
            am_cnt_next = am_cnt_reg + 9'h001;
      end
      // Shake peak / peak-to-peak counter
      if (sample_in.valid && have_prev_reg) begin
         case (sh_state_reg)
            MED_SH_IDLE: begin
               if (shake_hit) begin
                  sh_state_next  = MED_SH_PEAK;
                  shake_cnt_next = 4'h1;
                  width_next     = 12'h000;
               end
            end
            MED_SH_PEAK: begin
               if (!shake_now) begin
                  sh_state_next = MED_SH_GAP;
                  width_next    = 12'h000;
               end else if (width_reg > peak_width_threshold_reg) begin
                  if (shake_cnt_reg != 4'hf)
                     shake_cnt_next = shake_cnt_reg + 4'h1;
                  width_next = 12'h000;
               end else begin
                  width_next = width_reg + 12'h001;
               end
            end
            MED_SH_GAP: begin
               if (shake_now) begin
                  sh_state_next = MED_SH_PEAK;
                  width_next    = 12'h000;
               end else if (width_reg > peak_width_threshold_reg) begin
                  if (shake_cnt_reg != 4'hf)
                     shake_cnt_next = shake_cnt_reg + 4'h1;
                  width_next = 12'h000;
               end else begin
                  width_next = width_reg + 12'h001;
               end
            end
            default: sh_state_next = MED_SH_IDLE;
         endcase
      end
      if (shake_cnt_reg > {1'b0, shake_count_threshold_reg}) begin
         stat_next[SHAKE_BIT] = 1'b1;
         shake_cnt_next = 4'h0;
         sh_state_next  = MED_SH_IDLE;
      end
      // Tilt-35 must hold for the programmed span of 10 Hz ticks
      if (!tilt35_cond_in) begin
         t35_cnt_next = 6'h00;
      end else if (tick_reg) begin
         if (t35_cnt_reg + 6'h01 >= t35_len)
            stat_next[T35_BIT] = 1'b1;
         else
            t35_cnt_next = t35_cnt_reg + 6'h01;
      end
      // Temporary latch: pulse held for the period, then re-armed
      if (!timer_ctrl_reg[LATCH_EN_BIT]) begin
         latch_next  = 1'b0;
         tp_cnt_next = 7'h00;
      end else if (latch_reg) begin
         if (tick_reg) begin
            if (tp_cnt_reg + 7'h01 >= tp_len) begin
               latch_next  = 1'b0;
               tp_cnt_next = 7'h00;
            end else begin
               tp_cnt_next = tp_cnt_reg + 7'h01;
            end
         end
      end else if (|(stat_next[4:0] & ~stat_reg[4:0])) begin
         latch_next = 1'b1;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         stat_reg      <= 8'h00;
         sh_state_reg  <= MED_SH_IDLE;
         width_reg     <= 12'h000;
         shake_cnt_reg <= 4'h0;
         tf_cnt_reg    <= 9'h000;
         tf_tilt_reg   <= 1'b0;
         am_cnt_reg    <= 9'h000;
         t35_cnt_reg   <= 6'h00;
         tp_cnt_reg    <= 7'h00;
         latch_reg     <= 1'b0;
      end else begin
         stat_reg      <= stat_next;
         sh_state_reg  <= sh_state_next;
         width_reg     <= width_next;
         shake_cnt_reg <= shake_cnt_next;
         tf_cnt_reg    <= tf_cnt_next;
         tf_tilt_reg   <= tf_tilt_next;
         am_cnt_reg    <= am_cnt_next;
         t35_cnt_reg   <= t35_cnt_next;
         tp_cnt_reg    <= tp_cnt_next;
         latch_reg     <= latch_next;
      end
   end

   assign int_status_out = stat_reg;
   assign temp_latch_out = latch_reg;

   a_motion_sets: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      motion_hit |=> stat_reg[MOTION_BIT]) else $error("motion flag not set");
   a_motion_quiet: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      $fell(stat_reg[MOTION_BIT]) && !$past(host_clr) |-> $past(am_cnt_reg) >= {1'b0, $past(motion_hold_time_reg)})
      else $error("motion cleared early");
   a_shake_sets: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      shake_cnt_reg > {1'b0, shake_count_threshold_reg} |=> stat_reg[SHAKE_BIT])
      else $error("shake flag missing");
   a_latch_gated: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      !timer_ctrl_reg[LATCH_EN_BIT] |=> !latch_reg) else $error("latch while disabled");
   a_tilt_debounce: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      $rose(stat_reg[TILT_BIT]) |-> $past(tf_cnt_reg) > {1'b0, $past(tilt_flip_debounce_time_reg)})
      else $error("tilt set before debounce");
   a_t35_needs_tick: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      $rose(stat_reg[T35_BIT]) |-> $past(tick_reg) && $past(tilt35_cond_in))
      else $error("tilt35 set off tick");
   a_tick_spacing: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      tick_reg |=> !tick_reg [*8]) else $error("tick too frequent");
   a_flags_stick: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      stat_reg[SHAKE_BIT] && !host_clr |=> stat_reg[SHAKE_BIT]) else $error("shake flag dropped");
endmodule : med_core
`default_nettype wire

// ### test/med_host.sv
// Host-side model: register writes and the sample stream into the motion detector.
// Assumes the bench calls its tasks; every change is made at the falling edge.
`timescale 1ns/1ns
`default_nettype none
module med_host
   import med_pkg::*;
(
   // Clock
   input  wire logic           ref_clk_in,
   // Towards the detector
   output var med_pkg::med_wr_t     reg_wr_out,
   output var med_pkg::med_sample_t sample_out
);
   initial begin
      reg_wr_out = '0;
      sample_out = '0;
   end

   // Released lines show the inverse of the last value so nothing stale looks fresh
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      @(negedge ref_clk_in);
      reg_wr_out <= '{wr: 1'b1, addr: addr, data: data};
      @(negedge ref_clk_in);
      reg_wr_out <= '{wr: 1'b0, addr: ~addr, data: ~data};
   endtask : write_reg

   task automatic send_sample(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
      @(negedge ref_clk_in);
      sample_out <= '{valid: 1'b1, x: x, y: y, z: z};
      @(negedge ref_clk_in);
      sample_out <= '{valid: 1'b0, x: ~x, y: ~y, z: ~z};
   endtask : send_sample
endmodule : med_host
`default_nettype wire

// ### test/motion_event_detector_test.sv
// Self-checking bench for the motion event detector core.
// Assumes the host model drives writes and samples; slow-tick timeouts are too long to run out here.
`timescale 1ns/1ns
`default_nettype none
`define CHECK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin n_errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module motion_event_detector_test;
   import med_pkg::*;
   logic                ref_clk_in = 1'b0;
   logic                rst_in     = 1'b1;
   med_wr_t             reg_wr;
   med_sample_t         sample;
   logic [14:0]         orientation_threshold = 15'h1000;
   logic                tilt35_cond = 1'b0;
   logic [7:0]          int_status;
   logic                temp_latch;
   int                  n_errors = 0;
   int                  cmp_count = 0;

   always #5 ref_clk_in = ~ref_clk_in;

   med_host med_host_inst (.ref_clk_in(ref_clk_in), .reg_wr_out(reg_wr), .sample_out(sample));
   med_core med_core_inst (
      .ref_clk_in               (ref_clk_in),
      .rst_in                   (rst_in),
      .reg_wr_in                (reg_wr),
      .sample_in                (sample),
      .orientation_threshold_in (orientation_threshold),
      .tilt35_cond_in           (tilt35_cond),
      .int_status_out           (int_status),
      .temp_latch_out           (temp_latch)
   );

   // Sample, then let the registered flags settle before anyone looks
   task automatic samp(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
      med_host_inst.send_sample(x, y, z);
      repeat (2) @(negedge ref_clk_in);
   endtask : samp

   task automatic clear_status(input logic [7:0] mask);
      med_host_inst.write_reg(INT_STAT_ADDR, mask);
      repeat (2) @(negedge ref_clk_in);
   endtask : clear_status

   task automatic test_reset;
      `CHECK(int_status, 8'h00)
      `CHECK(temp_latch, 1'b0)
      $display("test reset done");
   endtask : test_reset

   task automatic test_motion;
      med_host_inst.write_reg(AM_THR_L_ADDR, 8'h00);
      med_host_inst.write_reg(AM_THR_H_ADDR, 8'h01);
      med_host_inst.write_reg(ANYMOTION_DEBOUNCE_ADDR, 8'h03);
      med_host_inst.write_reg(SHAKE_DELTA_THRESHOLD_L_ADDR, 8'hff);
      med_host_inst.write_reg(SHAKE_DELTA_THRESHOLD_H_ADDR, 8'h7f);
      // Unmapped offset must leave the thresholds alone
      med_host_inst.write_reg(8'h4b, 8'h00);
      samp(16'h0000, 16'h0000, 16'h0000);
      samp(16'h0100, 16'h0000, 16'h0000);
      `CHECK(int_status[MOTION_BIT], 1'b0)
      samp(16'h0201, 16'h0000, 16'h0000);
      `CHECK(int_status[MOTION_BIT], 1'b1)
      clear_status(8'h04);
      `CHECK(int_status[MOTION_BIT], 1'b0)
      samp(16'h0201, 16'hfeff, 16'h0000);
      `CHECK(int_status[MOTION_BIT], 1'b1)
      samp(16'h0201, 16'hfeff, 16'h0000);
      `CHECK(int_status[MOTION_BIT], 1'b1)
      repeat (4) samp(16'h0201, 16'hfeff, 16'h0000);
      `CHECK(int_status[MOTION_BIT], 1'b0)
      $display("test motion done");
   endtask : test_motion

   task automatic test_shake;
      med_host_inst.write_reg(AM_THR_L_ADDR, 8'hff);
      med_host_inst.write_reg(AM_THR_H_ADDR, 8'h7f);
      // Prime first so the first swing under the low threshold starts from an all-zero sample
      samp(16'h0000, 16'h0000, 16'h0000);
      med_host_inst.write_reg(SHAKE_DELTA_THRESHOLD_L_ADDR, 8'h00);
      med_host_inst.write_reg(SHAKE_DELTA_THRESHOLD_H_ADDR, 8'h02);
      med_host_inst.write_reg(PK_L_ADDR, 8'h00);
      med_host_inst.write_reg(PK_H_ADDR, 8'h20);
      clear_status(8'hff);
      // A swing equal to the threshold is not a shake
      for (int i = 0; i < 10; i++) samp(i[0] ? 16'h0000 : 16'h0200, 16'h0000, 16'h0000);
      `CHECK(int_status[SHAKE_BIT], 1'b0)
      for (int i = 0; i < 16; i++) begin
         samp(i[0] ? 16'h0000 : 16'h0201, 16'h0000, 16'h0000);
         if (int_status[SHAKE_BIT] === 1'b1) break;
      end
      `CHECK(int_status[SHAKE_BIT], 1'b1)
      // One short peak, then only the quiet gap keeps the count going
      clear_status(8'h08);
      samp(16'h0000, 16'h0000, 16'h0000);
      repeat (4) samp(16'h0000, 16'h0000, 16'h0000);
      `CHECK(int_status[SHAKE_BIT], 1'b0)
      samp(16'h0000, 16'h0000, 16'h0000);
      `CHECK(int_status[SHAKE_BIT], 1'b1)
      $display("test shake done");
   endtask : test_shake

   task automatic test_tilt;
      med_host_inst.write_reg(TILT_FLIP_DEBOUNCE_ADDR, 8'h03);
      samp(16'h0000, 16'h0000, 16'h0000);
      clear_status(8'hff);
      repeat (3) samp(16'h0000, 16'h0000, 16'h2000);
      `CHECK(int_status[TILT_BIT], 1'b0)
      repeat (3) samp(16'h0000, 16'h0000, 16'h2000);
      `CHECK(int_status[TILT_BIT], 1'b1)
      clear_status(8'hff);
      repeat (6) samp(16'h0000, 16'h0000, 16'h0100);
      `CHECK(int_status[FLIP_BIT], 1'b1)
      $display("test tilt done");
   endtask : test_tilt

   task automatic test_latch;
      med_host_inst.write_reg(AM_THR_L_ADDR, 8'h00);
      med_host_inst.write_reg(AM_THR_H_ADDR, 8'h01);
      med_host_inst.write_reg(TIMER_ADDR, 8'h00);
      clear_status(8'hff);
      samp(16'h0400, 16'h0000, 16'h0100);
      `CHECK(int_status[MOTION_BIT], 1'b1)
      `CHECK(temp_latch, 1'b0)
      med_host_inst.write_reg(TIMER_ADDR, 8'h80);
      clear_status(8'hff);
      samp(16'h0000, 16'h0000, 16'h0100);
      `CHECK(temp_latch, 1'b1)
      tilt35_cond = 1'b1;
      // Far below one slow tick, so neither timer may have expired
      repeat (2000) @(negedge ref_clk_in);
      `CHECK(temp_latch, 1'b1)
      `CHECK(int_status[T35_BIT], 1'b0)
      tilt35_cond = 1'b0;
      $display("test latch done");
   endtask : test_latch

   task automatic complete_run;
      $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : complete_run

   initial begin
      repeat (20) @(negedge ref_clk_in);
      rst_in = 1'b0;
      @(negedge ref_clk_in);
      test_reset();
      test_motion();
      test_shake();
      test_tilt();
      test_latch();
      complete_run();
   end
endmodule : motion_event_detector_test
`default_nettype wire
